/* File: verification/sdc_assertions.sv */
module sdc_assertions (
    // System
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic dout_oe,
    // Converter core
    input wire logic conv_restart,
    input wire logic conv_run
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_OE_ON:
        assert property ($fell(cs_n) |-> ##[1:4] dout_oe)
        else $error("Data line not driven after select");
    AST_OE_OFF:
        assert property ($rose(cs_n) |-> ##[1:4] !dout_oe)
        else $error("Data line still driven after deselect");
    AST_CS_LEAD:
        assert property ($fell(sclk) |-> !$past(cs_n, 8))
        else $error("Serial clock fell too soon after select");
    AST_SCLK_HALF:
        assert property ($fell(sclk) |=> !sclk [*7] ##1 sclk)
        else $error("Serial clock low phase not eight cycles");
    AST_SCLK_IDLE:
        assert property (cs_n |-> sclk)
        else $error("Serial clock low while deselected");
    AST_RESTART_PULSE:
        assert property (conv_restart |=> !conv_restart)
        else $error("Restart longer than one cycle");
    AST_RUN_RESTART:
        assert property (conv_restart |-> conv_run)
        else $error("Restart while powered down");
    AST_WAKE_CONVERT:
        assert property ($rose(conv_run) |-> ##[0:200] conv_restart)
        else $error("No conversion started after power-up");
endmodule

/* File: verification/tb_sigma_delta_adc_serial_control.sv */
`include "sdc_params.svh"
module tb_sigma_delta_adc_serial_control;
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // Bench state
    // ----
    // Slow enough rate that a 40-bit read fits inside one settle
    localparam int FSU    = 4;
    localparam int SETTLE = 4 * 96 * FSU;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, err;
    logic [3:0]  conv_chan;
    logic        conv_restart, conv_run;
    wire  [23:0] conv_sample = {20'ha5a5a, conv_chan};
    int fails = 0, checked = 0, cyc = 0, last = 0, gap = 0, nrst = 0;

    sdc_link_if link ();
    sdc_dev #(.OSC_CYC(50), .FS_UNIT(FSU)) sdc_dev_i (
        .pclk(pclk), .presetn(presetn), .link(link),
        .conv_sample(conv_sample), .conv_chan(conv_chan),
        .conv_restart(conv_restart), .conv_run(conv_run));
    sdc_host #(.HALF(8), .WAIT_CYC(40)) sdc_host_i (
        .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    sdc_assertions sdc_assertions_i (
        .pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
        .sclk(link.sclk), .dout_oe(link.dout_oe),
        .conv_restart(conv_restart), .conv_run(conv_run));

    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (conv_restart === 1'b1) begin
            gap = cyc - last;
            last = cyc;
            nrst = nrst + 1;
        end
    end
    // ----
    // Shared tasks
    // ----
    task automatic summarize();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic timeout();
        fails++;
        summarize();
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) timeout();
        @(posedge pclk);
    endtask
    task automatic poll(input logic [31:0] mask);
        int n;
        for (n = 0; n < 2000; n++) begin
            apb(1'b0, `SDC_A_STAT, 32'h0);
            if ((q & mask) === 32'h0) break;
        end
        if (n >= 2000) timeout();
    endtask
    // Select is kept low throughout, so ready shows on the line
    task automatic xfer(input logic [7:0] cmd, input logic [5:0] nb,
                        input logic [23:0] wd);
        apb(1'b1, `SDC_A_CTRL, {23'h0, 1'b1, 2'h0, nb});
        apb(1'b1, `SDC_A_WDATA, {8'h0, wd});
        apb(1'b1, `SDC_A_CMD, {24'h0, cmd});
        poll(32'h1);
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [5:0] nb);
        xfer(cmd, nb, 24'h0);
        apb(1'b0, `SDC_A_RDATA, 32'h0);
    endtask
    task automatic wait_line(input logic v);
        int n;
        for (n = 0; n < 5000 && link.dout_line !== v; n++)
            @(posedge pclk);
        if (n >= 5000) timeout();
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_power_on();
        rd(8'h50, 6'd24);
        chk("config", q, 32'h000117);
        rd(8'h48, 6'd24);
        chk("mode", q, 32'h080060);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", {err, q[30:0]}, 32'h80000000);
    endtask
    task automatic t_sequencer();
        int i;
        xfer(8'h10, 6'd24, 24'h000317);
        xfer(8'h08, 6'd24, 24'h100060);
        for (i = 0; i < 2; i++) begin
            wait_line(1'b0);
            apb(1'b0, `SDC_A_STAT, 32'h0);
            chk("ready", q & 32'h2, 32'h2);
            rd(8'h58, 6'd32);
            chk("chan", {28'h0, q[3:0]}, 32'(i));
            chk("word", q[31:8], {8'h0, 20'ha5a5a, 4'(i)});
            chk("rdy", {31'h0, link.dout_line}, 32'h1);
        end
        chk("settle", 32'(gap), 32'(SETTLE));
    endtask
    task automatic t_single();
        int n;
        int p;
        // Second pass starts from power-down, so the wake-up is seen too
        for (p = 0; p < 2; p++) begin
            xfer(8'h08, 6'd24, 24'h200060);
            nrst = 0;
            for (n = 0; n < 20000 && conv_run !== 1'b0; n++)
                @(posedge pclk);
            if (n >= 20000) timeout();
            chk("restarts", 32'(nrst), 32'd2);
        end
        rd(8'h48, 6'd24);
        chk("mode", q, 32'h600060);
        rd(8'h58, 6'd24);
        chk("last", q, 32'h00a5a5a1);
        // Nothing converts now, so ready must stay high on the line
        repeat (SETTLE) @(posedge pclk);
        chk("idle", {31'h0, link.dout_line}, 32'h1);
    endtask
    task automatic t_serial_reset();
        apb(1'b1, `SDC_A_CTRL, 32'h300);
        poll(32'h5);
        rd(8'h48, 6'd24);
        chk("mode", q, 32'h080060);
        rd(8'h50, 6'd24);
        chk("config", q, 32'h000117);
    endtask
    // Select framed around one read, released afterwards
    task automatic t_framed();
        apb(1'b1, `SDC_A_CTRL, 32'h18);
        apb(1'b1, `SDC_A_WDATA, 32'h0);
        apb(1'b1, `SDC_A_CMD, 32'h50);
        poll(32'h1);
        apb(1'b0, `SDC_A_RDATA, 32'h0);
        chk("framed", q, 32'h000117);
        chk("released", {31'h0, link.dout_oe}, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_power_on();
        t_sequencer();
        t_single();
        t_serial_reset();
        t_framed();
        summarize();
    end
endmodule

/* File: verilog/sdc_dev.sv */
// Behaviour
// - enabled channels are converted in turn
// - channel select restarts filter, ready high
// - ready low on valid result, next channel
// - per channel settle is four output periods
// - first transfer is always a command byte
// - write is command then data bits
// - four-wire link clocked by serial clock
// - line low on new word, high after read
// - ready high just before data update
// - select gates link; may stay low
// - data may be reread until next update
// - host idles serial clock high
// - select low presents the first bit; device shows ready, data only after a read command
// - forty ones reset interface and registers
// - host waits after a serial reset
// - single mode wakes, converts, powers down
// - single mode ready stays high after read
// - single mode converts each channel once
// - append status byte, channel in low bits
// - continuous mode after reset, ready per result
// - result discarded while data is being read
// - continuous mode loops all enabled channels
`include "sdc_params.svh"
module sdc_dev #(
    parameter int OSC_CYC = `SDC_OSC_US * `SDC_CLK_MHZ,
    parameter int FS_UNIT = 64
) (
    // System
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Link
    sdc_link_if.dev          link,
    // Converter core
    input  wire logic [23:0] conv_sample,
    output logic      [3:0]  conv_chan,
    output logic             conv_restart,
    output logic             conv_run
);
    import sdc_pkg::*;

    if (OSC_CYC < 1 || FS_UNIT < 1 || FS_UNIT > 4096) begin : g_bad_param
        $error("sdc_dev: bad timing parameter");
    end

    sdc_dev_t r;
    sdc_dev_t n;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [4:0] next_ch(input logic [7:0] en,
                                           input logic [3:0] from);
        logic [4:0] res;
        res = 5'h00;
        for (int i = `SDC_NCH - 1; i >= 0; i--) begin
            if (en[i] && 4'(i) >= from) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] settle_cyc(input logic [9:0] fs);
        logic [31:0] f;
        f = (fs == 10'h000) ? 32'h1 : {22'h0, fs};
        // Count runs down to zero inclusive, so start one short
        return 32'(`SDC_SETTLE_PER) * f * 32'(FS_UNIT) - 32'h1;
    endfunction

    logic       rise;
    logic       fall;
    logic       sel;
    logic       bit_in;
    logic [7:0] en;
    logic [2:0] md;
    logic [4:0] nx;
    logic [4:0] first;
    logic [7:0] cmd;
    logic [7:0] stat;

    always_comb begin
        n = r;
        n.restart = 1'b0;
        n.kick = 1'b0;
        n.cs_p = {r.cs_p[0], link.cs_n};
        n.sck_p = {r.sck_p[1:0], link.sclk};
        n.din_p = {r.din_p[0], link.din};
        rise = r.sck_p[1] & ~r.sck_p[2];
        fall = ~r.sck_p[1] & r.sck_p[2];
        sel = ~r.cs_p[1];
        bit_in = r.din_p[1];
        en = r.conf[`SDC_EN_HI:`SDC_EN_LO];
        md = r.mode[`SDC_MD_HI:`SDC_MD_LO];
        first = next_ch(en, 4'h0);
        nx = next_ch(en, r.chan + 4'h1);
        cmd = {r.shin[6:0], bit_in};
        stat = {r.rdy_n, 3'h0, r.dchan};

        // ----------------------------------------
        // Channel sequencer
        // ----------------------------------------
        case (r.cnv)
            CNV_WAKE: begin
                n.tmr = r.tmr - 32'h1;
                if (r.tmr == 32'h0) begin
                    n.cnv = first[4] ? CNV_SETTLE : CNV_OFF;
                    n.chan = first[3:0];
                    n.tmr = settle_cyc(r.mode[`SDC_FS_HI:0]);
                    n.restart = first[4];
                end
            end
            CNV_SETTLE: begin
                n.tmr = r.tmr - 32'h1;
                if (r.tmr == 32'h1) begin
                    n.rdy_n = 1'b1;
                end
                if (r.tmr == 32'h0) begin
                    // Late reader loses the fresh word, not the old one
                    if (!r.reading) begin
                        n.data = conv_sample;
                        n.dchan = r.chan;
                        n.rdy_n = 1'b0;
                    end
                    n.tmr = settle_cyc(r.mode[`SDC_FS_HI:0]);
                    n.restart = 1'b1;
                    if (nx[4]) begin
                        n.chan = nx[3:0];
                    end else if (md == `SDC_MD_SINGLE) begin
                        n.cnv = CNV_OFF;
                        n.restart = 1'b0;
                        n.mode[`SDC_MD_HI:`SDC_MD_LO] = `SDC_MD_PDOWN;
                    end else begin
                        n.chan = first[3:0];
                    end
                end
            end
            default: ;
        endcase

        if (r.kick) begin
            n.rdy_n = 1'b1;
            n.cnv = CNV_OFF;
            if (md == `SDC_MD_CONT && first[4]) begin
                n.cnv = CNV_SETTLE;
                n.chan = first[3:0];
                n.tmr = settle_cyc(r.mode[`SDC_FS_HI:0]);
                n.restart = 1'b1;
            end else if (md == `SDC_MD_SINGLE) begin
                n.cnv = CNV_WAKE;
                n.tmr = 32'(OSC_CYC - 1);
            end
        end

        // ----------------------------------------
        // Serial interface
        // ----------------------------------------
        if (!sel) begin
            n.ser = SER_CMD;
            n.bcnt = 6'h00;
            n.blen = `SDC_CMD_LEN;
            n.ones = 6'h00;
            n.reading = 1'b0;
            n.oe = 1'b0;
        end else begin
            n.oe = 1'b1;
            if (rise) begin
                n.ones = bit_in ? r.ones + 6'h01 : 6'h00;
                n.shin = {r.shin[22:0], bit_in};
                n.bcnt = r.bcnt + 6'h01;
                if (r.bcnt + 6'h01 == r.blen) begin
                    n.bcnt = 6'h00;
                    n.ser = SER_CMD;
                    n.blen = `SDC_CMD_LEN;
                    n.reading = 1'b0;
                    case (r.ser)
                        SER_CMD: begin
                            n.rs = cmd[`SDC_RS_HI:`SDC_RS_LO];
                            if (cmd[`SDC_WEN_BIT]) begin
                                n.ser = SER_CMD;
                            end else if (cmd[`SDC_RW_BIT]) begin
                                n.ser = SER_RD;
                                n.blen = `SDC_LEN_WORD;
                                n.shout = 32'h0;
                                case (cmd[`SDC_RS_HI:`SDC_RS_LO])
                                    `SDC_RS_STAT: begin
                                        n.blen = `SDC_LEN_STAT;
                                        n.shout = {stat, 24'h0};
                                    end
                                    `SDC_RS_MODE: n.shout = {r.mode, 8'h0};
                                    `SDC_RS_CONF: n.shout = {r.conf, 8'h0};
                                    `SDC_RS_DATA: begin
                                        n.reading = 1'b1;
                                        n.shout = {r.data, stat};
                                        if (r.mode[`SDC_APPEND_BIT]) begin
                                            n.blen = `SDC_LEN_DSTAT;
                                        end
                                    end
                                    default: n.ser = SER_CMD;
                                endcase
                            end else if (cmd[`SDC_RS_HI:`SDC_RS_LO] ==
                                         `SDC_RS_MODE ||
                                         cmd[`SDC_RS_HI:`SDC_RS_LO] ==
                                         `SDC_RS_CONF) begin
                                n.ser = SER_WR;
                                n.blen = `SDC_LEN_WORD;
                            end
                        end
                        SER_WR: begin
                            // Any write restarts the sequence cleanly
                            n.kick = 1'b1;
                            if (r.rs == `SDC_RS_MODE) begin
                                n.mode = {r.shin[22:0], bit_in};
                            end else begin
                                n.conf = {r.shin[22:0], bit_in};
                            end
                        end
                        SER_RD: begin
                            if (r.rs == `SDC_RS_DATA) begin
                                n.rdy_n = 1'b1;
                            end
                        end
                        default: n.ser = SER_CMD;
                    endcase
                end
                if (bit_in && r.ones + 6'h01 == `SDC_RST_ONES) begin
                    n.ser = SER_CMD;
                    n.bcnt = 6'h00;
                    n.blen = `SDC_CMD_LEN;
                    n.ones = 6'h00;
                    n.reading = 1'b0;
                    n.mode = `SDC_MODE_RST;
                    n.conf = `SDC_CONF_RST;
                    n.data = 24'h0;
                    n.dchan = 4'h0;
                    n.kick = 1'b1;
                end
            end
            if (fall && r.ser == SER_RD && r.bcnt != 6'h00) begin
                n.shout = {r.shout[30:0], 1'b0};
            end
        end
        // Ready shares the data pin outside a read
        n.dout = (n.ser == SER_RD) ? n.shout[31] : n.rdy_n;
        n.run = (n.cnv != CNV_OFF);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.cs_p <= 2'h3;
            r.sck_p <= 3'h7;
            r.blen <= `SDC_CMD_LEN;
            r.dout <= 1'b1;
            r.rdy_n <= 1'b1;
            r.mode <= `SDC_MODE_RST;
            r.conf <= `SDC_CONF_RST;
            r.kick <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign link.dout = r.dout;
    assign link.dout_oe = r.oe;
    assign conv_chan = r.chan;
    assign conv_restart = r.restart;
    assign conv_run = r.run;
endmodule

/* File: verilog/sdc_host.sv */
`include "sdc_params.svh"
module sdc_host #(
    parameter int HALF     = 8,
    parameter int WAIT_CYC = `SDC_SRST_US * `SDC_CLK_MHZ
) (
    // System
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link
    sdc_link_if.host         link
);
    import sdc_pkg::*;

    // Data returns five clocks after a fall; a shorter half misses it
    if (HALF < 6 || HALF > 255 || WAIT_CYC < 1) begin : g_bad_param
        $error("sdc_host: bad timing parameter");
    end

    sdc_host_t r;
    sdc_host_t n;
    logic      acc;
    logic      wr;
    logic      go;
    logic      idle;

    always_comb begin
        n = r;
        n.dout_p = {r.dout_p[0], link.dout_line};
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        acc = psel & penable & ~r.pready;
        wr = psel & penable & pwrite & r.pready;
        idle = (r.st == HST_IDLE);
        go = 1'b0;
        // ----------------------------------------
        // Register access
        // ----------------------------------------
        if (acc) begin
            n.pready = 1'b1;
            n.prdata = 32'h0;
            case (paddr)
                `SDC_A_CMD:   n.prdata = {24'h0, r.cmd};
                `SDC_A_WDATA: n.prdata = r.wdata;
                `SDC_A_CTRL:  n.prdata = {23'h0, r.keep, 2'h0, r.len};
                `SDC_A_RDATA: n.prdata = r.rx;
                `SDC_A_STAT:  n.prdata = {29'h0, r.st == HST_WAIT,
                                          ~r.dout_p[1], ~idle};
                default:      n.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            case (paddr)
                `SDC_A_CMD: begin
                    n.cmd = pwdata[7:0];
                    go = idle;
                end
                `SDC_A_WDATA: n.wdata = pwdata;
                `SDC_A_CTRL: begin
                    n.len = (pwdata[5:0] > `SDC_LEN_DSTAT) ?
                            `SDC_LEN_DSTAT : pwdata[5:0];
                    n.keep = pwdata[`SDC_KEEP_BIT];
                    if (idle) begin
                        n.cs_n = ~pwdata[`SDC_KEEP_BIT];
                        n.srst = pwdata[`SDC_SRST_BIT];
                        go = pwdata[`SDC_SRST_BIT];
                    end
                end
                default: ;
            endcase
        end
        // ----------------------------------------
        // Link engine
        // ----------------------------------------
        case (r.st)
            HST_SHIFT: begin
                if (r.half != 8'h00) begin
                    n.half = r.half - 8'h01;
                end else begin
                    n.half = 8'(HALF - 1);
                    if (r.sclk) begin
                        if (r.bits == r.total) begin
                            n.din = 1'b0;
                            n.cs_n = ~r.keep;
                            n.st = r.srst ? HST_WAIT : HST_IDLE;
                            n.wtmr = 32'(WAIT_CYC - 1);
                            n.srst = 1'b0;
                        end else begin
                            n.sclk = 1'b0;
                            n.din = r.tx[`SDC_TX_W - 1];
                            n.tx = {r.tx[`SDC_TX_W - 2:0], 1'b0};
                        end
                    end else begin
                        if (r.bits >= `SDC_CMD_LEN) begin
                            n.rx = {r.rx[30:0], r.dout_p[1]};
                        end
                        n.sclk = 1'b1;
                        n.bits = r.bits + 6'h01;
                    end
                end
            end
            HST_WAIT: begin
                n.wtmr = r.wtmr - 32'h1;
                if (r.wtmr == 32'h0) begin
                    n.st = HST_IDLE;
                end
            end
            default: ;
        endcase
        if (go) begin
            n.st = HST_SHIFT;
            n.cs_n = 1'b0;
            n.sclk = 1'b1;
            n.half = 8'(HALF - 1);
            n.bits = 6'h00;
            n.rx = 32'h0;
            if (n.srst) begin
                n.tx = '1;
                n.total = `SDC_RST_ONES;
            end else begin
                n.tx = {pwdata[7:0], r.wdata << (6'd32 - r.len)};
                n.total = `SDC_CMD_LEN + r.len;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.sclk <= 1'b1;
            r.cs_n <= 1'b1;
            r.dout_p <= 2'h3;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign link.sclk = r.sclk;
    assign link.cs_n = r.cs_n;
    assign link.din = r.din;
endmodule

/* File: verilog/sdc_link_if.sv */
interface sdc_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe;
    logic dout_line;
    // Pull-up while the device lets go
    assign dout_line = dout_oe ? dout : 1'b1;
    modport dev  (input cs_n, sclk, din, output dout, dout_oe);
    modport host (output cs_n, sclk, din, input dout_line);
endinterface

/* File: verilog/sdc_params.svh */
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH
// ----------------------------------------
// Serial framing
// ----------------------------------------
`define SDC_CMD_LEN     6'd8
`define SDC_WEN_BIT     7
`define SDC_RW_BIT      6
`define SDC_RS_HI       5
`define SDC_RS_LO       3
`define SDC_RST_ONES    6'd40
`define SDC_TX_W        40
// ----------------------------------------
// Device register selects and widths
// ----------------------------------------
`define SDC_RS_STAT     3'h0
`define SDC_RS_MODE     3'h1
`define SDC_RS_CONF     3'h2
`define SDC_RS_DATA     3'h3
`define SDC_LEN_STAT    6'd8
`define SDC_LEN_WORD    6'd24
`define SDC_LEN_DSTAT   6'd32
// ----------------------------------------
// Fields and power-on values
// ----------------------------------------
`define SDC_MODE_RST    24'h080060
`define SDC_CONF_RST    24'h000117
`define SDC_MD_HI       23
`define SDC_MD_LO       21
`define SDC_APPEND_BIT  20
`define SDC_SIXTY_HZ_NOTCH_ENABLE_BIT   13
`define SDC_FS_HI       9
`define SDC_EN_HI       15
`define SDC_EN_LO       8
`define SDC_MD_CONT     3'h0
`define SDC_MD_SINGLE   3'h1
`define SDC_MD_PDOWN    3'h3
`define SDC_NCH         8
// ----------------------------------------
// Timing
// ----------------------------------------
`define SDC_CLK_MHZ     100
`define SDC_OSC_US      1000
`define SDC_SRST_US     500
`define SDC_SETTLE_PER  4
// ----------------------------------------
// Controller register map (APB)
// ----------------------------------------
`define SDC_A_CMD       8'h00
`define SDC_A_WDATA     8'h04
`define SDC_A_CTRL      8'h08
`define SDC_A_RDATA     8'h0c
`define SDC_A_STAT      8'h10
`define SDC_KEEP_BIT    8
`define SDC_SRST_BIT    9
`endif

/* File: verilog/sdc_pkg.sv */
package sdc_pkg;
    typedef enum logic [1:0] {
        SER_CMD = 2'b00,
        SER_WR  = 2'b01,
        SER_RD  = 2'b10
    } sdc_ser_t;
    typedef enum logic [1:0] {
        CNV_OFF    = 2'b00,
        CNV_WAKE   = 2'b01,
        CNV_SETTLE = 2'b10
    } sdc_cnv_t;
    typedef enum logic [1:0] {
        HST_IDLE  = 2'b00,
        HST_SHIFT = 2'b01,
        HST_WAIT  = 2'b10
    } sdc_hst_t;
    typedef struct packed {
        logic [1:0]  cs_p;
        logic [2:0]  sck_p;
        logic [1:0]  din_p;
        sdc_ser_t    ser;
        logic [5:0]  bcnt;
        logic [5:0]  blen;
        logic [2:0]  rs;
        logic [23:0] shin;
        logic [31:0] shout;
        logic [5:0]  ones;
        logic        dout;
        logic        oe;
        logic        rdy_n;
        logic        reading;
        logic [23:0] mode;
        logic [23:0] conf;
        logic [23:0] data;
        logic [3:0]  dchan;
        sdc_cnv_t    cnv;
        logic [3:0]  chan;
        logic [31:0] tmr;
        logic        kick;
        logic        restart;
        logic        run;
    } sdc_dev_t;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [7:0]  cmd;
        logic [31:0] wdata;
        logic [5:0]  len;
        logic        keep;
        sdc_hst_t    st;
        logic [7:0]  half;
        logic        sclk;
        logic        cs_n;
        logic        din;
        logic [39:0] tx;
        logic [5:0]  bits;
        logic [5:0]  total;
        logic [31:0] rx;
        logic [31:0] wtmr;
        logic        srst;
        logic [1:0]  dout_p;
    } sdc_host_t;
endpackage
